// ### rtl/ars_regs.vh
// constants for the auto-recloser sequencer
`ifndef ARS_REGS_VH
`define ARS_REGS_VH
// tick of 0.005 s from a 250 MHz clock
`define ARS_CLK_HZ        250000000
`define ARS_TICK_US       5000
`define ARS_TICK_CYCLES   ((`ARS_CLK_HZ / 1000000) * `ARS_TICK_US)
// timer settings are counts of ticks, 0..360000 (1800 s)
`define ARS_TIME_W        19
`define ARS_TIME_MAX      19'd360000
`define ARS_NUM_REQ       5
`define ARS_NUM_SHOT      5
// per request setting bus: five shots, each four timers
`define ARS_SHOT_W        (4 * `ARS_TIME_W)
`define ARS_REQ_W         (`ARS_NUM_SHOT * `ARS_SHOT_W)
`define ARS_F_START       2'd0
`define ARS_F_DEAD        2'd1
`define ARS_F_ACTION      2'd2
`define ARS_F_RECLAIM     2'd3
// states
`define ARS_S_IDLE        4'd0
`define ARS_S_START       4'd1
`define ARS_S_ARC         4'd2
`define ARS_S_OPEN        4'd3
`define ARS_S_DEAD        4'd4
`define ARS_S_CLOSE       4'd5
`define ARS_S_RECLAIM     4'd6
`define ARS_S_LOCK        4'd7
`endif

// ### rtl/ars_tick.v
// prescaler making the 0.005 s timer tick
`timescale 1ns/10ps
`default_nettype none
`include "ars_regs.vh"
module ars_tick #(
	parameter integer CYCLES = `ARS_TICK_CYCLES
) (
	input  wire ref_clk,
	input  wire rst_n,
	input  wire restart,
	output reg  tick
);
	reg [20:0] cnt_reg;

	always @(posedge ref_clk) begin
		if (!rst_n || restart) begin
			cnt_reg <= 21'h00_0000;
			tick    <= 1'b0;
		end else if (cnt_reg == CYCLES[20:0] - 21'h00_0001) begin
			cnt_reg <= 21'h00_0000;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 21'h00_0001;
			tick    <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### rtl/ars_sequencer.v
// auto-recloser sequencer: requests, shots, breaker commands and lock-out
// Functional notes
// - after breaker opens, wait the shot dead time, then command close.
// - an uncleared shot leads to the next shot or final trip and lock.
// - per shot of a start request, choose a fixed arcing delay or rely on protection timing.
// - fault back in reclaim: arm next shot or final trip, per setting.
// - five reclose requests, the first highest, the fifth lowest priority.
// - a critical request stops reclosing at once in any state.
// - five enable bits per request; each shot has four timers, 0..1800 s.
// - trip requests start directly; start requests wait the starting delay.
// - higher-priority request during reclaim takes over with its own settings.
// - locked, close attempts are refused until a manual reset or a breaker close.
// - open and close go only through the breaker object, status comes back.
// - object wait state holds the sequencer until success or failure.
// - any open or close failure acknowledgement forces lock-out.
// - lock-out ends on the reset input or with the breaker closed.
// - request during reclaim ends that shot and moves to the next enabled shot, or to final trip and lock.
// - hold close until breaker closed, then drop it and start reclaim.
// - no enabled shot left: final trip, clear indications, lock-out.
`timescale 1ns/10ps
`default_nettype none
`include "ars_regs.vh"
module ars_sequencer (
	input  wire                  ref_clk,
	input  wire                  rst_n,
	// protection requests, asynchronous to this clock
	input  wire [4:0]            request_in,
	input  wire                  critical_request,
	// settings, static
	input  wire [4:0]            req_is_start,
	input  wire [24:0]           shot_enable,
	input  wire [24:0]           shot_use_arc,
	input  wire [24:0]           shot_arm_next,
	input  wire [`ARS_REQ_W-1:0] top_priority_request_set,
	input  wire [`ARS_REQ_W-1:0] second_priority_request_set,
	input  wire [`ARS_REQ_W-1:0] third_priority_request_set,
	input  wire [`ARS_REQ_W-1:0] fourth_priority_request_set,
	input  wire [`ARS_REQ_W-1:0] lowest_priority_request_set,
	// lock reset sources
	input  wire                  lock_reset,
	// breaker object
	input  wire                  brk_closed,
	input  wire                  brk_open,
	input  wire                  obj_wait,
	input  wire                  obj_open_fail,
	input  wire                  obj_close_fail,
	output reg                   open_cmd,
	output reg                   close_cmd,
	// indications
	output reg                   ar_running,
	output reg  [4:0]            shot_running,
	output reg  [4:0]            req_requested,
	output reg                   final_trip,
	output reg                   locked_out,
	output reg                   waiting
);
	// ======================================================
	// input synchronisers
	localparam integer NS = 12;
	reg [NS-1:0] s1_reg;
	reg [NS-1:0] s2_reg;
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			s1_reg <= {NS{1'b0}};
			s2_reg <= {NS{1'b0}};
		end else begin
			s1_reg <= {request_in, critical_request, lock_reset, brk_closed, brk_open,
				obj_wait, obj_open_fail, obj_close_fail};
			s2_reg <= s1_reg;
		end
	end
	wire [4:0] req_s    = s2_reg[11:7];
	wire       crit_s   = s2_reg[6];
	wire       rst_s    = s2_reg[5];
	wire       closed_s = s2_reg[4];
	wire       open_s   = s2_reg[3];
	wire       wait_s   = s2_reg[2];
	wire       ofail_s  = s2_reg[1];
	wire       cfail_s  = s2_reg[0];
	wire       fail_s   = ofail_s | cfail_s;

	// ======================================================
	// priority selection
	reg [2:0] pick;
	always @* begin
		pick = 3'd7;
		if (req_s[4]) pick = 3'd4;
		if (req_s[3]) pick = 3'd3;
		if (req_s[2]) pick = 3'd2;
		if (req_s[1]) pick = 3'd1;
		if (req_s[0]) pick = 3'd0;
	end
	wire any_req = (pick != 3'd7);

	reg  [3:0] state_reg;
	reg  [2:0] req_reg;
	reg  [2:0] shot_reg;
	reg  [`ARS_TIME_W-1:0] time_reg;
	reg        req_seen_reg;

	reg [`ARS_REQ_W-1:0] set_bus;
	always @* begin
		case (req_reg)
		3'd0: set_bus = top_priority_request_set;
		3'd1: set_bus = second_priority_request_set;
		3'd2: set_bus = third_priority_request_set;
		3'd3: set_bus = fourth_priority_request_set;
		default: set_bus = lowest_priority_request_set;
		endcase
	end
	function [`ARS_TIME_W-1:0] tval;
		input [`ARS_REQ_W-1:0] bus;
		input [2:0] shot;
		input [1:0] field;
		begin
			tval = bus[(shot * 4 + field) * `ARS_TIME_W +: `ARS_TIME_W];
		end
	endfunction
	// first enabled shot of request r at or after shot s
	function [2:0] next_shot;
		input [24:0] en;
		input [2:0] r;
		input [2:0] s;
		integer k;
		begin
			next_shot = 3'd7;
			for (k = 4; k >= 0; k = k - 1)
				if (k >= s && en[r * 5 + k])
					next_shot = k[2:0];
		end
	endfunction

	wire       new_shot;
	wire       tick;
	ars_tick u_tick (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.restart (new_shot),
		.tick    (tick)
	);
	wire [4:0] sidx = {2'b00, req_reg} * 5'd5 + {2'b00, shot_reg};

	// ======================================================
	// sequence state machine
	reg  [3:0] st_next;
	reg  [2:0] rq_next;
	reg  [2:0] sh_next;
	reg  [2:0] cand;
	reg        restart;
	always @* begin
		st_next = state_reg;
		rq_next = req_reg;
		sh_next = shot_reg;
		restart = 1'b0;
		cand    = 3'd7;
		case (state_reg)
		`ARS_S_IDLE: begin
			if (any_req) begin
				cand = next_shot(shot_enable, pick, 3'd0);
				rq_next = pick;
				sh_next = cand;
				restart = 1'b1;
				if (cand == 3'd7)
					st_next = `ARS_S_LOCK;
				else if (req_is_start[pick])
					st_next = `ARS_S_START;
				else
					st_next = `ARS_S_OPEN;
			end
		end
		`ARS_S_START: begin
			if (time_reg >= tval(set_bus, shot_reg, `ARS_F_START)) begin
				restart = 1'b1;
				st_next = shot_use_arc[sidx] ? `ARS_S_ARC : `ARS_S_OPEN;
			end
		end
		`ARS_S_ARC: begin
			if (time_reg >= tval(set_bus, shot_reg, `ARS_F_ACTION)) begin
				restart = 1'b1;
				st_next = `ARS_S_OPEN;
			end
		end
		`ARS_S_OPEN: begin
			if (open_s && !req_s[req_reg]) begin
				restart = 1'b1;
				st_next = `ARS_S_DEAD;
			end
		end
		`ARS_S_DEAD: begin
			if (time_reg >= tval(set_bus, shot_reg, `ARS_F_DEAD)) begin
				restart = 1'b1;
				st_next = `ARS_S_CLOSE;
			end
		end
		`ARS_S_CLOSE: begin
			if (closed_s) begin
				restart = 1'b1;
				st_next = `ARS_S_RECLAIM;
			end
		end
		`ARS_S_RECLAIM: begin
			if (any_req) begin
				// higher priority takes over from the next shot position
				rq_next = (pick < req_reg) ? pick : req_reg;
				cand = (pick < req_reg) ? next_shot(shot_enable, pick, shot_reg + 3'd1)
					: (shot_arm_next[sidx] ? next_shot(shot_enable, req_reg, shot_reg + 3'd1)
					: 3'd7);
				sh_next = cand;
				restart = 1'b1;
				if (cand == 3'd7)
					st_next = `ARS_S_LOCK;
				else if (req_is_start[rq_next])
					st_next = `ARS_S_START;
				else
					st_next = `ARS_S_OPEN;
			end else if (time_reg >= tval(set_bus, shot_reg, `ARS_F_RECLAIM)) begin
				st_next = `ARS_S_IDLE;
			end
		end
		`ARS_S_LOCK: begin
			if (rst_s || closed_s)
				st_next = `ARS_S_IDLE;
		end
		default: st_next = `ARS_S_IDLE;
		endcase
		if (crit_s || fail_s) begin
			st_next = `ARS_S_LOCK;
			restart = 1'b0;
		end
	end
	assign new_shot = restart;

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg <= `ARS_S_IDLE;
			req_reg   <= 3'd0;
			shot_reg  <= 3'd0;
			time_reg  <= {`ARS_TIME_W{1'b0}};
			req_seen_reg <= 1'b0;
		end else begin
			state_reg <= st_next;
			req_reg   <= (st_next == `ARS_S_LOCK || rq_next > 3'd4) ? req_reg : rq_next;
			shot_reg  <= (sh_next == 3'd7) ? shot_reg : sh_next;
			req_seen_reg <= any_req;
			if (restart)
				time_reg <= {`ARS_TIME_W{1'b0}};
			else if (tick && time_reg != `ARS_TIME_MAX)
				time_reg <= time_reg + {{(`ARS_TIME_W-1){1'b0}}, 1'b1};
		end
	end

	// ======================================================
	// outputs
	wire busy = (st_next != `ARS_S_IDLE) && (st_next != `ARS_S_LOCK);
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			open_cmd      <= 1'b0;
			close_cmd     <= 1'b0;
			ar_running    <= 1'b0;
			shot_running  <= 5'h0;
			req_requested <= 5'h0;
			final_trip    <= 1'b0;
			locked_out    <= 1'b0;
			waiting       <= 1'b0;
		end else begin
			open_cmd      <= (st_next == `ARS_S_OPEN) && !open_s;
			close_cmd     <= (st_next == `ARS_S_CLOSE);
			ar_running    <= busy;
			shot_running  <= busy ? (5'h01 << ((sh_next == 3'd7) ? shot_reg : sh_next)) : 5'h0;
			req_requested <= busy ? (5'h01 << ((rq_next > 3'd4) ? req_reg : rq_next)) : 5'h0;
			final_trip    <= (st_next == `ARS_S_LOCK) && (state_reg != `ARS_S_LOCK);
			locked_out    <= (st_next == `ARS_S_LOCK);
			waiting       <= (state_reg == `ARS_S_CLOSE) && wait_s;
		end
	end
endmodule
`default_nettype wire

// ### sim/ars_seq_chk.sv
// concurrent checks on the auto-recloser sequencer ports
`timescale 1ns/10ps
`default_nettype none
module ars_seq_chk (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       critical_request,
	input wire logic       lock_reset,
	input wire logic       brk_closed,
	input wire logic       brk_open,
	input wire logic       obj_open_fail,
	input wire logic       obj_close_fail,
	input wire logic       open_cmd,
	input wire logic       close_cmd,
	input wire logic       ar_running,
	input wire logic [4:0] shot_running,
	input wire logic [4:0] req_requested,
	input wire logic       final_trip,
	input wire logic       locked_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// breaker handshake and lock reset steps
	sequence s_closed_seen;
		close_cmd ##0 brk_closed [*3];
	endsequence
	sequence s_opened_seen;
		open_cmd ##0 brk_open [*3];
	endsequence
	sequence s_clean_reset;
		(lock_reset && !critical_request && !obj_open_fail && !obj_close_fail) [*3];
	endsequence
	a_close_locked: assert property (locked_out |-> !close_cmd)
		else $error("close command while locked");
	a_close_release: assert property (s_closed_seen |-> ##[0:3] !close_cmd)
		else $error("close command held after breaker closed");
	a_open_release: assert property (s_opened_seen |-> ##[0:3] !open_cmd)
		else $error("open command held after breaker open");
	a_crit_lock: assert property (critical_request [*2] |-> ##[0:4] locked_out)
		else $error("critical request did not lock");
	a_fail_lock: assert property ((obj_open_fail || obj_close_fail) [*2] |-> ##[0:4] locked_out)
		else $error("failure did not lock");
	a_reset_unlock: assert property (s_clean_reset |-> ##1 !locked_out)
		else $error("lock reset ignored");
	a_trip_clear: assert property (final_trip |-> !ar_running && shot_running == 5'h00
		&& req_requested == 5'h00 ##1 !final_trip)
		else $error("final trip not a clean pulse");
	a_one_hot: assert property ($onehot0(shot_running) && $onehot0(req_requested))
		else $error("shot or request indication not one-hot");
	a_open_running: assert property ($rose(open_cmd) |-> ar_running && req_requested != 5'h00)
		else $error("open command without a running sequence");
endmodule
bind ars_sequencer ars_seq_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.critical_request(critical_request), .lock_reset(lock_reset), .brk_closed(brk_closed),
	.brk_open(brk_open), .obj_open_fail(obj_open_fail), .obj_close_fail(obj_close_fail),
	.open_cmd(open_cmd), .close_cmd(close_cmd), .ar_running(ar_running),
	.shot_running(shot_running), .req_requested(req_requested), .final_trip(final_trip),
	.locked_out(locked_out));
`default_nettype wire

// ### sim/ars_brk_model.sv
// behavioural breaker object facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module ars_brk_model (
	input wire logic  ref_clk,
	input wire logic  open_cmd,
	input wire logic  close_cmd,
	input wire logic  prot_trip,
	input wire logic  man_close,
	input wire logic  slow,
	output var logic  brk_open,
	output var logic  brk_closed,
	output var logic  obj_wait
);
	int wait_cnt = 0;
	initial begin
		brk_open = 1'b0;
		brk_closed = 1'b1;
		obj_wait = 1'b0;
	end
	always @(posedge ref_clk) begin
		if ((open_cmd || prot_trip) && brk_closed) begin
			brk_closed <= 1'b0;
			brk_open <= 1'b1;
		end else if ((close_cmd || man_close) && brk_open) begin
			if (slow && wait_cnt < 6) begin
				obj_wait <= 1'b1;
				wait_cnt <= wait_cnt + 1;
			end else begin
				brk_open <= 1'b0;
				brk_closed <= 1'b1;
				obj_wait <= 1'b0;
				wait_cnt <= 0;
			end
		end
	end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the auto-recloser sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ars_regs.vh"
module testbench;
	typedef struct {logic [4:0] req; logic [4:0] exp; logic start; logic arc; logic slow;} ars_row_t;
	logic ref_clk = 0, rst_n = 0, critical_request = 0, lock_reset = 0, prot_trip = 0;
	logic obj_open_fail = 0, obj_close_fail = 0, man_close = 0, slow = 0;
	logic [4:0] request_in = 5'h00, req_is_start = 5'h00;
	logic [24:0] shot_enable = 25'h1ff_ffff, shot_use_arc = 25'h000_0000;
	logic [24:0] arm_next = 25'h1ff_ffff;
	logic [`ARS_REQ_W-1:0] tset = '0;
	logic [`ARS_REQ_W-1:0] rset = '0;
	wire brk_open, brk_closed, obj_wait, open_cmd, close_cmd, ar_running, final_trip, locked_out;
	wire waiting;
	wire [4:0] shot_running, req_requested;
	int miscompares = 0, n_checks = 0, i;
	ars_row_t rows [5] = '{'{5'h01, 5'h01, 0, 0, 0}, '{5'h06, 5'h02, 1, 0, 1},
		'{5'h1c, 5'h04, 0, 1, 0}, '{5'h18, 5'h08, 1, 1, 1}, '{5'h10, 5'h10, 0, 0, 0}};
	always #2 ref_clk = ~ref_clk;
	ars_sequencer dut (.ref_clk(ref_clk), .rst_n(rst_n), .request_in(request_in),
		.critical_request(critical_request), .req_is_start(req_is_start),
		.shot_enable(shot_enable), .shot_use_arc(shot_use_arc), .shot_arm_next(arm_next),
		.top_priority_request_set(tset), .second_priority_request_set(rset),
		.third_priority_request_set(tset), .fourth_priority_request_set(tset),
		.lowest_priority_request_set(tset), .lock_reset(lock_reset), .brk_closed(brk_closed),
		.brk_open(brk_open), .obj_wait(obj_wait), .obj_open_fail(obj_open_fail),
		.obj_close_fail(obj_close_fail), .open_cmd(open_cmd), .close_cmd(close_cmd),
		.ar_running(ar_running), .shot_running(shot_running), .req_requested(req_requested),
		.final_trip(final_trip), .locked_out(locked_out), .waiting(waiting));
	ars_brk_model u_brk (.ref_clk(ref_clk), .open_cmd(open_cmd), .close_cmd(close_cmd),
		.prot_trip(prot_trip), .man_close(man_close), .slow(slow), .brk_open(brk_open),
		.brk_closed(brk_closed), .obj_wait(obj_wait));
	task finish_test;
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task check(input logic [4:0] seen, input logic [4:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
			miscompares++;
		end
	endtask
	// bounded wait on one output: 0 open, 1 close, 2 running, 3 locked, 4 waiting, 5 trip
	task wait_for(input int sel, input logic lvl);
		logic [5:0] v;
		for (int n = 0; n < 300; n++) begin
			@(negedge ref_clk);
			v = {final_trip, waiting, locked_out, ar_running, close_cmd, open_cmd};
			if (v[sel] === lvl)
				return;
		end
		$display("CHECK FAILED at %0t: wait %0d timed out", $time, sel);
		miscompares++;
		finish_test();
	endtask
	initial begin
		repeat (8) @(negedge ref_clk);
		check({open_cmd, close_cmd, ar_running, final_trip, locked_out}, 5'h00);
		rst_n = 1;
		for (i = 0; i < 5; i++) begin
			req_is_start = {4'h0, rows[i].start} << i;
			shot_use_arc = {24'h00_0000, rows[i].arc} << (i * 5);
			slow = rows[i].slow;
			request_in = rows[i].req;
			wait_for(0, 1'b1);
			check(req_requested, rows[i].exp);
			check(shot_running, 5'h01);
			wait_for(0, 1'b0);
			request_in = 5'h00;
			if (slow)
				wait_for(4, 1'b1);
			wait_for(1, 1'b1);
			wait_for(1, 1'b0);
			wait_for(2, 1'b0);
			$display("row %0d done", i);
		end
		slow = 0;
		critical_request = 1;
		prot_trip = 1;
		wait_for(3, 1'b1);
		critical_request = 0;
		prot_trip = 0;
		repeat (20) @(negedge ref_clk);
		check({close_cmd, locked_out, 3'h0}, 5'h08);
		man_close = 1;
		wait_for(3, 1'b0);
		man_close = 0;
		$display("critical lock done");
		// protection opens the breaker itself, so the lock is not left at once
		shot_enable = 25'h00f_ffff;
		request_in = 5'h10;
		prot_trip = 1;
		wait_for(5, 1'b1);
		check({final_trip, ar_running, 3'h0}, 5'h10);
		request_in = 5'h00;
		prot_trip = 0;
		shot_enable = 25'h1ff_ffff;
		man_close = 1;
		wait_for(3, 1'b0);
		man_close = 0;
		$display("no shot done");
		obj_open_fail = 1;
		request_in = 5'h01;
		wait_for(3, 1'b1);
		check({close_cmd, 4'h0}, 5'h00);
		obj_open_fail = 0;
		request_in = 5'h00;
		lock_reset = 1;
		wait_for(3, 1'b0);
		lock_reset = 0;
		$display("failure lock done");
		// reclaim of one tick never runs out here, so requests land inside it
		rset[3 * `ARS_TIME_W +: `ARS_TIME_W] = 19'h0_0001;
		rset[7 * `ARS_TIME_W +: `ARS_TIME_W] = 19'h0_0001;
		request_in = 5'h02;
		wait_for(0, 1'b1);
		wait_for(0, 1'b0);
		request_in = 5'h00;
		wait_for(1, 1'b1);
		wait_for(1, 1'b0);
		check(shot_running, 5'h01);
		request_in = 5'h02;
		wait_for(0, 1'b1);
		check(shot_running, 5'h02);
		check(req_requested, 5'h02);
		wait_for(0, 1'b0);
		request_in = 5'h00;
		wait_for(1, 1'b1);
		wait_for(1, 1'b0);
		request_in = 5'h01;
		wait_for(0, 1'b1);
		check(req_requested, 5'h01);
		check(shot_running, 5'h04);
		wait_for(0, 1'b0);
		request_in = 5'h00;
		wait_for(2, 1'b0);
		$display("reclaim done");
		arm_next[5] = 1'b0;
		request_in = 5'h02;
		wait_for(0, 1'b1);
		wait_for(0, 1'b0);
		request_in = 5'h00;
		wait_for(1, 1'b1);
		wait_for(1, 1'b0);
		request_in = 5'h02;
		prot_trip = 1;
		wait_for(5, 1'b1);
		check({final_trip, ar_running, 3'h0}, 5'h10);
		check(shot_running, 5'h00);
		request_in = 5'h00;
		prot_trip = 0;
		repeat (8) @(negedge ref_clk);
		check({close_cmd, locked_out, 3'h0}, 5'h08);
		lock_reset = 1;
		wait_for(3, 1'b0);
		lock_reset = 0;
		rset = '0;
		arm_next = 25'h1ff_ffff;
		$display("final trip done");
		finish_test();
	end
endmodule
`default_nettype wire
